/* verilog/iws_sequencer.sv */
`include "iws_defs.svh"

module iws_sequencer #(
   parameter int unsigned WAKE_CYCLES    = `IWS_WAKE_CYCLES,
   parameter int unsigned STANDBY_CYCLES = `IWS_STANDBY_CYCLES,
   parameter int unsigned DECAY_CYCLES   = `IWS_DECAY_CYCLES,
   parameter logic [6:0]  SLAVE_ADDR     = `IWS_SLAVE_ADDR
) (
   input  wire logic                    clk_i,
   input  wire logic                    rst_n_i,
   input  wire logic                    scl_i,
   input  wire logic                    sda_i,
   output logic                         sda_o,
   output logic                         sda_oe_o,
   input  wire logic                    peak_detect_i,
   output logic                         shutdown_o,
   output iws_pkg::iws_status_type      status_o,
   output iws_pkg::iws_rail_type        rail_o
);

   localparam int unsigned TW = `IWS_TIMER_W;
   localparam logic [TW-1:0] WAKE_LOAD = TW'(WAKE_CYCLES - 1);
   localparam logic [TW-1:0] SBY_LOAD  = TW'(STANDBY_CYCLES - 1);

   // Eighth bit of a byte is in: the next bus clock is the acknowledge slot
   function automatic logic at_ack_slot(input logic [`IWS_BIT_CNT_W-1:0] cnt);
      return cnt == `IWS_BITS_PER_BYTE;
   endfunction

   // Only a write to this device's own address is answered
   function automatic logic is_own_write(input logic [7:0] addr_byte);
      return addr_byte[7:1] == SLAVE_ADDR && !addr_byte[0];
   endfunction

   // Pointer walks through the control registers and wraps to the first
   function automatic logic [7:0] next_reg_ptr(input logic [7:0] ptr);
      if (ptr >= `IWS_REG_LAST || ptr < `IWS_REG_FIRST) begin
         return `IWS_REG_FIRST;
      end
      return ptr + 8'h01;
   endfunction

   // Status flags decoded from a power state
   function automatic iws_pkg::iws_status_type status_of(
      input iws_pkg::iws_pwr_state_type s
   );
      iws_pkg::iws_status_type r;
      r.standby     = s == iws_pkg::st_standby;
      r.waking      = s == iws_pkg::st_waking;
      r.entering    = s == iws_pkg::st_entering;
      r.operational = s == iws_pkg::st_active;
      r.supplies_en = s != iws_pkg::st_standby;
      return r;
   endfunction

   // ------------------------------------------------------------------
   // Link side: start detection, clocked by the data line itself
   // ------------------------------------------------------------------

   logic start_tgl_ff;

   // A falling data line while the bus clock is high marks a start
   always_ff @(negedge sda_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         start_tgl_ff <= 1'b0;
      end else if (scl_i) begin
         start_tgl_ff <= ~start_tgl_ff;
      end
   end

   // ------------------------------------------------------------------
   // Link side: bit reception on the rising bus clock
   // ------------------------------------------------------------------

   logic                       start_seen_ff;
   logic [`IWS_BIT_CNT_W-1:0]  bit_cnt_ff;
   logic [7:0]                 shift_ff;
   logic                       first_byte_ff;
   logic                       start_pend;

   // The start toggle settles while the clock is high, well before
   // the next rising edge, so the protocol itself orders the crossing.
   assign start_pend = start_tgl_ff != start_seen_ff;

   always_ff @(posedge scl_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         start_seen_ff <= 1'b0;
         bit_cnt_ff    <= '0;
         shift_ff      <= '0;
         first_byte_ff <= 1'b0;
      end else begin
         start_seen_ff <= start_tgl_ff;
         if (start_pend) begin
            // First address bit after a start
            bit_cnt_ff    <= `IWS_BIT_CNT_W'(1);
            shift_ff      <= {7'h00, sda_i};
            first_byte_ff <= 1'b1;
         end else if (at_ack_slot(bit_cnt_ff)) begin
            // Acknowledge clock
            bit_cnt_ff    <= '0;
            first_byte_ff <= 1'b0;
         end else begin
            bit_cnt_ff    <= bit_cnt_ff + `IWS_BIT_CNT_W'(1);
            shift_ff      <= {shift_ff[6:0], sda_i};
         end
      end
   end

   // ------------------------------------------------------------------
   // Link side: byte handling on the falling bus clock
   // ------------------------------------------------------------------

   iws_pkg::iws_link_phase_type phase_ff;
   logic [7:0]                  reg_ptr_ff;
   logic [7:0]                  mode_byte_ff;
   logic                        mode_tgl_ff;
   logic                        ack_ff;
   logic                        byte_done;

   assign byte_done = at_ack_slot(bit_cnt_ff);

   always_ff @(negedge scl_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_ff     <= iws_pkg::ph_ignore;
         reg_ptr_ff   <= '0;
         mode_byte_ff <= '0;
         mode_tgl_ff  <= 1'b0;
         ack_ff       <= 1'b0;
      end else if (byte_done) begin
         // Falling edge of the eighth bit of a byte
         if (first_byte_ff) begin
            if (is_own_write(shift_ff)) begin
               ack_ff   <= 1'b1;
               phase_ff <= iws_pkg::ph_reg;
            end else begin
               // Reads and other addresses are left unanswered
               ack_ff   <= 1'b0;
               phase_ff <= iws_pkg::ph_ignore;
            end
         end else begin
            case (phase_ff)
               iws_pkg::ph_reg: begin
                  ack_ff     <= 1'b1;
                  reg_ptr_ff <= shift_ff;
                  phase_ff   <= iws_pkg::ph_data;
               end
               iws_pkg::ph_data: begin
                  ack_ff <= 1'b1;
                  if (reg_ptr_ff == `IWS_REG_OUTPUT_MODE) begin
                     // Byte is held stable until the next toggle
                     mode_byte_ff <= shift_ff;
                     mode_tgl_ff  <= ~mode_tgl_ff;
                  end
                  // Further data bytes walk through the control registers
                  reg_ptr_ff <= next_reg_ptr(reg_ptr_ff);
               end
               default: begin
                  ack_ff <= 1'b0;
               end
            endcase
         end
      end else begin
         // Release the data line after the acknowledge clock
         ack_ff <= 1'b0;
      end
   end

   // Open-drain: only ever pull low
   assign sda_o    = 1'b0;
   assign sda_oe_o = ack_ff;

   // ------------------------------------------------------------------
   // System side: command crossing
   // ------------------------------------------------------------------

   logic mode_tgl_sync;
   logic mode_seen_ff;
   logic new_cmd;
   logic cmd_shutdown;
   logic peak_sync;

   iws_sync #(
      .WIDTH   (1)
   ) u_mode_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .async_i (mode_tgl_ff),
      .sync_o  (mode_tgl_sync)
   );

   iws_sync #(
      .WIDTH   (1)
   ) u_peak_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .async_i (peak_detect_i),
      .sync_o  (peak_sync)
   );

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_seen_ff <= 1'b0;
      end else begin
         mode_seen_ff <= mode_tgl_sync;
      end
   end

   assign new_cmd = mode_tgl_sync != mode_seen_ff;
   assign cmd_shutdown = mode_byte_ff[`IWS_SHUTDOWN_BIT];

   logic shutdown_ff;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shutdown_ff <= 1'b1;
      end else if (new_cmd) begin
         shutdown_ff <= cmd_shutdown;
      end
   end

   assign shutdown_o = shutdown_ff;

   // ------------------------------------------------------------------
   // System side: power-state sequencer
   // ------------------------------------------------------------------

   iws_pkg::iws_pwr_state_type state_ff;
   iws_pkg::iws_pwr_state_type nxt_state;
   logic [TW-1:0]              timer_ff;
   logic [TW-1:0]              nxt_timer;

   always_comb begin
      nxt_state = state_ff;
      nxt_timer = (timer_ff == '0) ? '0 : timer_ff - TW'(1);
      case (state_ff)
         iws_pkg::st_standby: begin
            if (new_cmd && !cmd_shutdown) begin
               nxt_state = iws_pkg::st_waking;
               nxt_timer = WAKE_LOAD;
            end
         end
         iws_pkg::st_waking: begin
            if (new_cmd && cmd_shutdown) begin
               nxt_state = iws_pkg::st_entering;
               nxt_timer = SBY_LOAD;
            end else if (timer_ff == '0) begin
               nxt_state = iws_pkg::st_active;
            end
         end
         iws_pkg::st_active: begin
            if (new_cmd && cmd_shutdown) begin
               nxt_state = iws_pkg::st_entering;
               nxt_timer = SBY_LOAD;
            end
         end
         iws_pkg::st_entering: begin
            if (new_cmd && !cmd_shutdown) begin
               nxt_state = iws_pkg::st_waking;
               nxt_timer = WAKE_LOAD;
            end else if (timer_ff == '0) begin
               nxt_state = iws_pkg::st_standby;
            end
         end
         default: begin
            nxt_state = iws_pkg::st_standby;
            nxt_timer = '0;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= iws_pkg::st_standby;
         timer_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         timer_ff <= nxt_timer;
      end
   end

   iws_pkg::iws_status_type status_ff;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status_ff <= '{standby: 1'b1, default: 1'b0};
      end else begin
         // Flags move at the same edge as the state itself
         status_ff <= status_of(nxt_state);
      end
   end

   assign status_o = status_ff;

   // ------------------------------------------------------------------
   // Class-G rail selection, live only while the outputs run
   // ------------------------------------------------------------------

   iws_rail_sel #(
      .DECAY_CYCLES (DECAY_CYCLES)
   ) u_rail_sel (
      .clk_i        (clk_i),
      .rst_n_i      (rst_n_i),
      .active_i     (status_ff.operational),
      .peak_i       (peak_sync),
      .rail_o       (rail_o)
   );

endmodule // iws_sequencer

/* verilog/iws_defs.svh */
// Notes on behaviour
// - Device acknowledges slave and register address bytes.
// - Wake starts at eighth data bit SCL fall.
// - Outputs operational only after de-pop interval.
// - Standby interval starts at eighth bit SCL fall.
// - Standby reached within standby interval after edge.
// - Low amplitude keeps converters at low rail.
// - Peak selects high rail until decay expires.
// - Output-mode control register is register address one.
// - Shutdown bit one standby, zero activates supplies.
`ifndef IWS_DEFS_SVH
`define IWS_DEFS_SVH

// Serial interface
`define IWS_SLAVE_ADDR        7'h40
`define IWS_REG_OUTPUT_MODE   8'h01
`define IWS_REG_FIRST         8'h01
`define IWS_REG_LAST          8'h03
`define IWS_SHUTDOWN_BIT      0
`define IWS_BITS_PER_BYTE     4'h8
`define IWS_BIT_CNT_W         4

// Timing
`define IWS_CLK_MHZ           100
`define IWS_WAKE_TIME_MS      12
`define IWS_STANDBY_TIME_US   100
`define IWS_DECAY_TIME_US     1000
`define IWS_WAKE_CYCLES       (`IWS_WAKE_TIME_MS * 1000 * `IWS_CLK_MHZ)
`define IWS_STANDBY_CYCLES    (`IWS_STANDBY_TIME_US * `IWS_CLK_MHZ)
`define IWS_DECAY_CYCLES      (`IWS_DECAY_TIME_US * `IWS_CLK_MHZ)
`define IWS_TIMER_W           21

`endif

/* verilog/iws_pkg.sv */
package iws_pkg;

   typedef enum logic [1:0] {
      st_standby,
      st_waking,
      st_active,
      st_entering
   } iws_pwr_state_type;

   typedef enum logic [1:0] {
      ph_reg,
      ph_data,
      ph_ignore
   } iws_link_phase_type;

   typedef enum logic {
      rail_low,
      rail_high
   } iws_rail_type;

   typedef struct packed {
      logic standby;
      logic waking;
      logic entering;
      logic operational;
      logic supplies_en;
   } iws_status_type;

endpackage : iws_pkg

/* verilog/iws_sync.sv */
module iws_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
      end
   end

   assign sync_o = sync_ff;

endmodule // iws_sync

/* verilog/iws_rail_sel.sv */
`include "iws_defs.svh"

module iws_rail_sel #(
   parameter int unsigned DECAY_CYCLES = `IWS_DECAY_CYCLES
) (
   input  wire logic           clk_i,
   input  wire logic           rst_n_i,
   input  wire logic           active_i,
   input  wire logic           peak_i,
   output iws_pkg::iws_rail_type rail_o
);

   localparam int unsigned CNT_W = $clog2(DECAY_CYCLES + 1);

   iws_pkg::iws_rail_type rail_ff;
   logic [CNT_W-1:0]      decay_ff;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rail_ff  <= iws_pkg::rail_low;
         decay_ff <= '0;
      end else if (!active_i) begin
         rail_ff  <= iws_pkg::rail_low;
         decay_ff <= '0;
      end else if (peak_i) begin
         // Peak raises the rail and restarts the hold time
         rail_ff  <= iws_pkg::rail_high;
         decay_ff <= CNT_W'(DECAY_CYCLES - 1);
      end else if (decay_ff != '0) begin
         decay_ff <= decay_ff - CNT_W'(1);
      end else begin
         rail_ff  <= iws_pkg::rail_low;
      end
   end

   assign rail_o = rail_ff;

endmodule // iws_rail_sel

/* testbench/iws_sequencer_monitor.sv */
module iws_sequencer_monitor #(
   parameter int unsigned WAKE_CYCLES    = 200,
   parameter int unsigned STANDBY_CYCLES = 50,
   parameter int unsigned DECAY_CYCLES   = 20
) (
   input wire logic                    clk_i,
   input wire logic                    rst_n_i,
   input wire logic                    scl_i,
   input wire logic                    sda_oe_o,
   input wire logic                    peak_detect_i,
   input wire logic                    shutdown_o,
   input wire iws_pkg::iws_status_type status_o,
   input wire iws_pkg::iws_rail_type   rail_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] run_ff;
   logic [31:0] quiet_ff;
   // Cycles spent in the present power state
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) run_ff <= 32'h0;
      else run_ff <= $changed(status_o) ? 32'h1 : run_ff + 32'h1;
   end
   // Cycles since the peak input last stood high
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) quiet_ff <= 32'h0;
      else quiet_ff <= peak_detect_i ? 32'h0 : quiet_ff + 32'h1;
   end
   a_wake_length: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(status_o.operational) |-> run_ff == WAKE_CYCLES) else $error("wake length");
   a_standby_length: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(status_o.standby) |-> run_ff == STANDBY_CYCLES) else $error("standby length");
   a_wake_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $fell(shutdown_o) && !status_o.operational |-> ##[0:2] status_o.waking)
      else $error("wake start");
   a_standby_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(shutdown_o) && !status_o.standby |-> ##[0:2] status_o.entering)
      else $error("standby start");
   a_standby_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      status_o.standby |-> !status_o.supplies_en && !status_o.operational)
      else $error("standby supplies");
   a_rail_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !status_o.operational [*2] |-> rail_o == iws_pkg::rail_low) else $error("rail low");
   a_rail_rise: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (peak_detect_i && status_o.operational) [*4] |-> rail_o == iws_pkg::rail_high)
      else $error("rail rise");
   a_rail_decay: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $fell(rail_o) && status_o.operational |->
      quiet_ff inside {[DECAY_CYCLES + 1:DECAY_CYCLES + 3]}) else $error("rail decay");
   a_ack_one: assert property (@(negedge scl_i) disable iff (!rst_n_i)
      $rose(sda_oe_o) |=> !sda_oe_o) else $error("ack length");
   c_wake: cover property (@(posedge clk_i) $rose(status_o.operational));
   c_sleep: cover property (@(posedge clk_i) $rose(status_o.standby));
   c_peak: cover property (@(posedge clk_i) $rose(rail_o));
   c_reverse: cover property (@(posedge clk_i) status_o.waking ##1 status_o.entering);
endmodule // iws_sequencer_monitor

bind iws_sequencer iws_sequencer_monitor #(
   .WAKE_CYCLES(WAKE_CYCLES), .STANDBY_CYCLES(STANDBY_CYCLES), .DECAY_CYCLES(DECAY_CYCLES)
) u_mon (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o),
   .peak_detect_i(peak_detect_i), .shutdown_o(shutdown_o), .status_o(status_o),
   .rail_o(rail_o)
);

/* testbench/iws_i2c_master.sv */
module iws_i2c_master (
   output logic     scl_o,
   output logic     sda_o,
   input wire logic sda_i
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned stretch_ns = 0;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // One bit cell; the low phase can be stretched to act as a slow master
   task automatic put_bit(input logic b, output logic seen);
      #10 sda_o = b;
      #(30 + stretch_ns) scl_o = 1'b1;
      seen = sda_i;
      #40 scl_o = 1'b0;
   endtask
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(b[i], s);
      end
      put_bit(1'b1, s);
      ack = !s;
   endtask
   task automatic frame(input logic [6:0] adr, input logic [7:0] ra, input logic [7:0] d,
                        output logic [2:0] acks);
      #3 sda_o = 1'b0;
      #20 scl_o = 1'b0;
      put_byte({adr, 1'b0}, acks[2]);
      put_byte(ra, acks[1]);
      put_byte(d, acks[0]);
      #10 sda_o = 1'b0;
      #30 scl_o = 1'b1;
      #20 sda_o = 1'b1;
   endtask
   // Two data bytes in one frame, so that the register pointer walks on
   task automatic frame_two(input logic [6:0] adr, input logic [7:0] ra, input logic [7:0] d,
                            input logic [7:0] d2, output logic [3:0] acks);
      #3 sda_o = 1'b0;
      #20 scl_o = 1'b0;
      put_byte({adr, 1'b0}, acks[3]);
      put_byte(ra, acks[2]);
      put_byte(d, acks[1]);
      put_byte(d2, acks[0]);
      #10 sda_o = 1'b0;
      #30 scl_o = 1'b1;
      #20 sda_o = 1'b1;
   endtask
endmodule // iws_i2c_master

/* testbench/iws_sequencer_tb_top.sv */
module iws_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned WAKE    = 400;
   localparam int unsigned STANDBY = 50;
   localparam int unsigned DECAY   = 20;
   localparam logic [6:0]  ADDR    = 7'h40;
   logic                    clk;
   logic                    rst_n;
   logic                    peak;
   logic                    scl;
   logic                    m_sda;
   logic                    sda_w;
   logic                    sda_oe;
   logic                    shutdown;
   logic                    sda_dev;
   iws_pkg::iws_status_type st;
   iws_pkg::iws_rail_type   rail;
   logic [2:0]              acks;
   logic [3:0]              acks4;
   int                      num_errors = 0;
   int                      samples_checked = 0;
   int                      busy_len = 0;
   int                      n;
   // Open-drain data line with pull-up
   assign sda_w = m_sda & (~sda_oe | sda_dev);
   iws_sequencer #(.WAKE_CYCLES(WAKE), .STANDBY_CYCLES(STANDBY), .DECAY_CYCLES(DECAY),
      .SLAVE_ADDR(ADDR)) dut (
      .clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_w),
      .sda_o(sda_dev), .sda_oe_o(sda_oe),
      .peak_detect_i(peak), .shutdown_o(shutdown), .status_o(st), .rail_o(rail));
   iws_i2c_master u_mst (.scl_o(scl), .sda_o(m_sda), .sda_i(sda_w));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Length of the running waking or entering interval
   always @(negedge clk) busy_len <= (st.waking | st.entering) ? busy_len + 1 : 0;
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic count_until(input int sel);
      n = 0;
      while (n < 2000 && !(sel == 0 ? st.operational === 1'b1 : sel == 1 ?
             st.standby === 1'b1 : rail === iws_pkg::rail_low)) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic t_refuse();
      u_mst.stretch_ns = 200;
      u_mst.frame(ADDR ^ 7'h01, 8'h01, 8'h00, acks);
      u_mst.stretch_ns = 0;
      chk("acks", acks, 3'h0);
      chk("shutdown", shutdown, 1'b1);
      chk("status", st, 5'h10);
   endtask
   task automatic t_wake();
      u_mst.frame(ADDR, 8'h01, 8'h00, acks);
      chk("acks", acks, 3'h7);
      chk("shutdown", shutdown, 1'b0);
      chk("waking", st.waking, 1'b1);
      chk("supplies", st.supplies_en, 1'b1);
      count_until(0);
      chk("wake len", busy_len, WAKE);
      chk("status", st, 5'h03);
   endtask
   task automatic t_rail();
      chk("rail idle", rail, iws_pkg::rail_low);
      @(negedge clk) peak = 1'b1;
      repeat (4) @(negedge clk);
      chk("rail peak", rail, iws_pkg::rail_high);
      @(negedge clk) peak = 1'b0;
      count_until(2);
      chk("decay", n >= DECAY + 1 && n <= DECAY + 3, 1'b1);
   endtask
   // Registers two and three take the bytes, the pointer then wraps to one
   task automatic t_other_reg();
      u_mst.frame_two(ADDR, 8'h02, 8'h01, 8'h01, acks4);
      chk("acks", acks4, 4'hf);
      repeat (10) @(negedge clk);
      chk("shutdown", shutdown, 1'b0);
      chk("status", st, 5'h03);
   endtask
   // First byte lands on register three, the second wraps to register one
   task automatic t_standby();
      u_mst.frame_two(ADDR, 8'h03, 8'h01, 8'h01, acks4);
      chk("acks", acks4, 4'hf);
      chk("shutdown", shutdown, 1'b1);
      chk("entering", st.entering, 1'b1);
      count_until(1);
      chk("standby len", busy_len, STANDBY);
      chk("status", st, 5'h10);
   endtask
   // Standby requested while still waking, then repeated while in standby
   task automatic t_reverse();
      u_mst.frame(ADDR, 8'h01, 8'h00, acks);
      chk("waking", st.waking, 1'b1);
      u_mst.frame(ADDR, 8'h01, 8'h01, acks);
      chk("acks", acks, 3'h7);
      chk("entering", st.entering, 1'b1);
      count_until(1);
      chk("standby within", n <= STANDBY, 1'b1);
      chk("status", st, 5'h10);
      @(negedge clk) peak = 1'b1;
      u_mst.frame(ADDR, 8'h01, 8'h01, acks);
      repeat (10) @(negedge clk);
      chk("rail off", rail, iws_pkg::rail_low);
      chk("standby hold", st, 5'h10);
      @(negedge clk) peak = 1'b0;
   endtask
   initial begin
      #100us;
      num_errors++;
      stop_test();
   end
   initial begin
      rst_n = 1'b0;
      peak = 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      repeat (2) @(negedge clk);
      chk("reset status", st, 5'h10);
      chk("reset shutdown", shutdown, 1'b1);
      chk("reset ack", sda_oe, 1'b0);
      t_refuse();
      t_wake();
      t_rail();
      t_other_reg();
      t_standby();
      t_reverse();
      stop_test();
   end
endmodule // iws_sequencer_tb_top
